// ### logic/quad_phase_pin_mux.sv
// function mux for the two pins that default to quadrature decoder 1 phase inputs
// assumes peripherals run on the core clock; pin inputs are asynchronous
//
// Operation
// [R1] on the full variant the first pin carries the decoder 1 phase A input after reset.
// [R2] on the full variant the second pin carries the decoder 1 phase B input after reset.
// [R3] on the reduced variant neither pin carries a listed function after reset.
// [R4] the phase A alternate select bit routes the spi 1 serial clock to the first pin.
// [R5] the phase B alternate select bit routes the spi 1 master-out data to the second pin.
// [R6] clearing port c pull-up bit 0 turns off the first pin's pull-up.
// [R7] clearing port c pull-up bit 1 turns off the second pin's pull-up.
// [R8] the spi clock pin is driven in master mode and is the clock input in slave mode.
// [R9] master-out data leads the sampling clock edge by half a cycle.
// [R10] each pin in port c gpio use has its own direction.
// [R11] selects are registered and a change takes effect on the next clock cycle.
`timescale 1ns/1ns
module quad_phase_pin_mux #(
    parameter bit FULL_VARIANT = 1'b1
) (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic I_PIN_A_IN,
    input wire logic I_PIN_B_IN,
    output logic O_PIN_A_OUT,
    output logic O_PIN_A_OE,
    output logic O_PIN_A_PULLUP,
    output logic O_PIN_B_OUT,
    output logic O_PIN_B_OE,
    output logic O_PIN_B_PULLUP,
    input wire logic I_SEL_WR,
    input wire logic [1:0] I_SEL_A,
    input wire logic [1:0] I_SEL_B,
    input wire logic I_PHASE_A_ALT_SELECT,
    input wire logic I_PHASE_B_ALT_SELECT,
    input wire logic [1:0] I_PORT_C_PULLUP,
    input wire logic [1:0] I_PORT_C_DIR,
    input wire logic [1:0] I_PORT_C_DATA,
    input wire logic I_TIMER_B_CH0_OUT,
    input wire logic I_TIMER_B_CH0_OE,
    input wire logic I_TIMER_B_CH1_OUT,
    input wire logic I_TIMER_B_CH1_OE,
    input wire logic I_SPI1_MASTER,
    input wire logic I_SPI1_CLOCK_OUT,
    input wire logic I_SPI1_MOSI_OUT,
    output logic O_QUAD1_PHASE_A_IN,
    output logic O_QUAD1_PHASE_B_IN,
    output logic O_TIMER_B_CH0_IN,
    output logic O_TIMER_B_CH1_IN,
    output logic O_SPI1_CLOCK_IN,
    output logic O_SPI1_MOSI_IN,
    output logic [1:0] O_PORT_C_IN
);
    // reset select depends on the variant; the reduced part comes up with no function
    localparam logic [1:0] SEL_RESET =
        FULL_VARIANT ? quad_phase_pin_mux_pkg::SEL_QUAD : quad_phase_pin_mux_pkg::SEL_NONE;

    // select state
    logic [1:0] sel_a_r;
    logic [1:0] sel_a_nxt;
    logic [1:0] sel_b_r;
    logic [1:0] sel_b_nxt;
    logic alt_a_r;
    logic alt_a_nxt;
    logic alt_b_r;
    logic alt_b_nxt;
    logic [1:0] pur_r;
    logic [1:0] pur_nxt;
    logic [1:0] dir_r;
    logic [1:0] dir_nxt;
    logic [1:0] dat_r;
    logic [1:0] dat_nxt;

    // peripheral input state
    logic quad_a_r;
    logic quad_a_nxt;
    logic quad_b_r;
    logic quad_b_nxt;
    logic tmr0_r;
    logic tmr0_nxt;
    logic tmr1_r;
    logic tmr1_nxt;
    logic sclk_r;
    logic sclk_nxt;
    logic mosi_r;
    logic mosi_nxt;
    logic [1:0] gpin_r;
    logic [1:0] gpin_nxt;

    logic [1:0] pin_sync;
    quad_phase_pin_mux_pkg::pin_func_t func_a;
    quad_phase_pin_mux_pkg::pin_func_t func_b;
    logic pin_a_out;
    logic pin_a_oe;
    logic pin_a_pu;
    logic pin_b_out;
    logic pin_b_oe;
    logic pin_b_pu;

    pin_sync2 u_sync (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_async({I_PIN_B_IN, I_PIN_A_IN}),
        .o_sync(pin_sync)
    );

    // select registers; the mux below reads only these, never the raw ports
    always_comb begin
        sel_a_nxt = sel_a_r;
        sel_b_nxt = sel_b_r;
        if (I_SEL_WR) begin
            sel_a_nxt = I_SEL_A; // [R11]
            sel_b_nxt = I_SEL_B; // [R11]
        end
        alt_a_nxt = I_PHASE_A_ALT_SELECT;
        alt_b_nxt = I_PHASE_B_ALT_SELECT;
        pur_nxt = I_PORT_C_PULLUP;
        dir_nxt = I_PORT_C_DIR;
        dat_nxt = I_PORT_C_DATA;
        if (!I_NRST) begin
            sel_a_nxt = SEL_RESET; // [R1] [R3]
            sel_b_nxt = SEL_RESET; // [R2] [R3]
            alt_a_nxt = 1'h0;
            alt_b_nxt = 1'h0;
            pur_nxt = quad_phase_pin_mux_pkg::PUR_RESET;
            dir_nxt = quad_phase_pin_mux_pkg::DIR_RESET;
            dat_nxt = quad_phase_pin_mux_pkg::DATA_RESET;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        sel_a_r <= sel_a_nxt;
        sel_b_r <= sel_b_nxt;
        alt_a_r <= alt_a_nxt;
        alt_b_r <= alt_b_nxt;
        pur_r <= pur_nxt;
        dir_r <= dir_nxt;
        dat_r <= dat_nxt;
    end

    // alternate bit wins over the select code
    assign func_a = quad_phase_pin_mux_pkg::decode_sel(alt_a_r, sel_a_r); // [R4] [R11]
    assign func_b = quad_phase_pin_mux_pkg::decode_sel(alt_b_r, sel_b_r); // [R5] [R11]

    // clock and data go through identical stages, so their half-cycle spacing survives
    pin_drive_cell u_cell_a (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_func(func_a),
        .i_timer_out(I_TIMER_B_CH0_OUT),
        .i_timer_oe(I_TIMER_B_CH0_OE),
        .i_spi_out(I_SPI1_CLOCK_OUT), // [R4] [R9]
        .i_spi_oe(I_SPI1_MASTER), // [R8]
        .i_gpio_out(dat_r[quad_phase_pin_mux_pkg::PUR_BIT_A]),
        .i_gpio_oe(dir_r[quad_phase_pin_mux_pkg::PUR_BIT_A]), // [R10]
        .i_pullup(pur_r[quad_phase_pin_mux_pkg::PUR_BIT_A]), // [R6]
        .o_out(pin_a_out),
        .o_oe(pin_a_oe),
        .o_pullup(pin_a_pu)
    );

    pin_drive_cell u_cell_b (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_func(func_b),
        .i_timer_out(I_TIMER_B_CH1_OUT),
        .i_timer_oe(I_TIMER_B_CH1_OE),
        .i_spi_out(I_SPI1_MOSI_OUT), // [R5] [R9]
        .i_spi_oe(I_SPI1_MASTER),
        .i_gpio_out(dat_r[quad_phase_pin_mux_pkg::PUR_BIT_B]),
        .i_gpio_oe(dir_r[quad_phase_pin_mux_pkg::PUR_BIT_B]), // [R10]
        .i_pullup(pur_r[quad_phase_pin_mux_pkg::PUR_BIT_B]), // [R7]
        .o_out(pin_b_out),
        .o_oe(pin_b_oe),
        .o_pullup(pin_b_pu)
    );

    // inputs to peripherals; an unselected peripheral sees the idle level, not the pin
    always_comb begin
        quad_a_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
        quad_b_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
        tmr0_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
        tmr1_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
        sclk_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
        mosi_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
        gpin_nxt = {2{quad_phase_pin_mux_pkg::IDLE_IN}};
        case (func_a)
            quad_phase_pin_mux_pkg::FN_QUAD: quad_a_nxt = pin_sync[0]; // [R1]
            quad_phase_pin_mux_pkg::FN_TIMER: tmr0_nxt = pin_sync[0];
            quad_phase_pin_mux_pkg::FN_SPI: sclk_nxt = pin_sync[0]; // [R8]
            quad_phase_pin_mux_pkg::FN_GPIO: gpin_nxt[0] = pin_sync[0];
            default: quad_a_nxt = quad_phase_pin_mux_pkg::IDLE_IN; // [R3]
        endcase
        case (func_b)
            quad_phase_pin_mux_pkg::FN_QUAD: quad_b_nxt = pin_sync[1]; // [R2]
            quad_phase_pin_mux_pkg::FN_TIMER: tmr1_nxt = pin_sync[1];
            quad_phase_pin_mux_pkg::FN_SPI: mosi_nxt = pin_sync[1];
            quad_phase_pin_mux_pkg::FN_GPIO: gpin_nxt[1] = pin_sync[1];
            default: quad_b_nxt = quad_phase_pin_mux_pkg::IDLE_IN; // [R3]
        endcase
        if (!I_NRST) begin
            quad_a_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
            quad_b_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
            tmr0_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
            tmr1_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
            sclk_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
            mosi_nxt = quad_phase_pin_mux_pkg::IDLE_IN;
            gpin_nxt = {2{quad_phase_pin_mux_pkg::IDLE_IN}};
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        quad_a_r <= quad_a_nxt;
        quad_b_r <= quad_b_nxt;
        tmr0_r <= tmr0_nxt;
        tmr1_r <= tmr1_nxt;
        sclk_r <= sclk_nxt;
        mosi_r <= mosi_nxt;
        gpin_r <= gpin_nxt;
    end

    assign O_PIN_A_OUT = pin_a_out;
    assign O_PIN_A_OE = pin_a_oe;
    assign O_PIN_A_PULLUP = pin_a_pu;
    assign O_PIN_B_OUT = pin_b_out;
    assign O_PIN_B_OE = pin_b_oe;
    assign O_PIN_B_PULLUP = pin_b_pu;
    assign O_QUAD1_PHASE_A_IN = quad_a_r;
    assign O_QUAD1_PHASE_B_IN = quad_b_r;
    assign O_TIMER_B_CH0_IN = tmr0_r;
    assign O_TIMER_B_CH1_IN = tmr1_r;
    assign O_SPI1_CLOCK_IN = sclk_r;
    assign O_SPI1_MOSI_IN = mosi_r;
    assign O_PORT_C_IN = gpin_r;

    // checks: pin paths are three flops deep, drive paths one flop behind the selects
    a_reset_phase_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R1]
        (FULL_VARIANT && !$past(I_NRST) && !alt_a_r)
        |-> (func_a == quad_phase_pin_mux_pkg::FN_QUAD))
        else $error("first pin not on phase A input after reset");

    a_quad_a_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R1]
        (func_a == quad_phase_pin_mux_pkg::FN_QUAD) |-> ##1 (quad_a_r == $past(pin_sync[0])))
        else $error("phase A input does not follow the first pin");

    a_reset_phase_b: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R2]
        (FULL_VARIANT && !$past(I_NRST) && !alt_b_r)
        |-> (func_b == quad_phase_pin_mux_pkg::FN_QUAD))
        else $error("second pin not on phase B input after reset");

    a_quad_b_follow: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R2]
        (func_b == quad_phase_pin_mux_pkg::FN_QUAD) |-> ##1 (quad_b_r == $past(pin_sync[1])))
        else $error("phase B input does not follow the second pin");

    a_reduced_no_func: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R3]
        (!FULL_VARIANT && !$past(I_NRST) && !alt_a_r && !alt_b_r && !I_SEL_WR)
        |-> ##1 (!pin_a_oe && !pin_b_oe && quad_a_r && quad_b_r))
        else $error("reduced variant left a function on a pin after reset");

    a_spi_clock_route: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R4]
        (alt_a_r && I_SPI1_MASTER) |-> ##1 (pin_a_oe && pin_a_out == $past(I_SPI1_CLOCK_OUT)))
        else $error("spi clock not routed to first pin");

    a_spi_mosi_route: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R5]
        (alt_b_r && I_SPI1_MASTER) |-> ##1 (pin_b_oe && pin_b_out == $past(I_SPI1_MOSI_OUT)))
        else $error("spi master-out not routed to second pin");

    a_pullup_off_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R6]
        (!I_PORT_C_PULLUP[0] ##1 I_NRST) |-> ##1 !pin_a_pu)
        else $error("first pin pull-up still on after bit 0 cleared");

    a_pullup_off_b: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R7]
        (!I_PORT_C_PULLUP[1] ##1 I_NRST) |-> ##1 !pin_b_pu)
        else $error("second pin pull-up still on after bit 1 cleared");

    a_slave_clock_in: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R8]
        (alt_a_r && !I_SPI1_MASTER) |-> ##1 (!pin_a_oe && sclk_r == $past(pin_sync[0])))
        else $error("slave-mode spi clock pin driven or not taken in");

    a_data_clock_align: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R9]
        (alt_a_r && alt_b_r && I_SPI1_MASTER)
        |-> ##1 (pin_a_out == $past(I_SPI1_CLOCK_OUT) && pin_b_out == $past(I_SPI1_MOSI_OUT)))
        else $error("spi clock and data skewed through the mux");

    a_gpio_own_dir: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R10]
        (func_a == quad_phase_pin_mux_pkg::FN_GPIO && func_b == quad_phase_pin_mux_pkg::FN_GPIO)
        |-> ##1 (pin_a_oe == $past(dir_r[0]) && pin_b_oe == $past(dir_r[1])))
        else $error("gpio direction not taken per pin");

    a_select_next_cycle: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R11]
        (I_SEL_WR && I_SEL_A == quad_phase_pin_mux_pkg::SEL_GPIO && !I_PHASE_A_ALT_SELECT)
        ##1 I_NRST |-> (func_a == quad_phase_pin_mux_pkg::FN_GPIO)
        ##1 (pin_a_oe == $past(dir_r[0])))
        else $error("select write did not take effect on the next cycle");

    a_mosi_slave_in: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R5]
        (alt_b_r && !I_SPI1_MASTER) |-> ##1 (!pin_b_oe && mosi_r == $past(pin_sync[1])))
        else $error("slave-mode master-out pin driven or not taken in");

    a_pullup_on_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R6]
        (I_PORT_C_PULLUP[0] ##1 I_NRST) |-> ##1 pin_a_pu)
        else $error("first pin pull-up off while bit 0 set");

    a_pullup_on_b: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R7]
        (I_PORT_C_PULLUP[1] ##1 I_NRST) |-> ##1 pin_b_pu)
        else $error("second pin pull-up off while bit 1 set");

    // a peripheral that lost its pin must not keep seeing stale pin levels
    a_timer_a_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R11]
        (func_a != quad_phase_pin_mux_pkg::FN_TIMER)
        |-> ##1 (tmr0_r == quad_phase_pin_mux_pkg::IDLE_IN))
        else $error("timer channel 0 input not idle while unselected");

    a_timer_b_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_NRST) // [R11]
        (func_b != quad_phase_pin_mux_pkg::FN_TIMER)
        |-> ##1 (tmr1_r == quad_phase_pin_mux_pkg::IDLE_IN))
        else $error("timer channel 1 input not idle while unselected");
endmodule : quad_phase_pin_mux

// ### logic/quad_phase_pin_mux_pkg.sv
// constants, function codes and select decode for the two-pin phase mux
// assumes one 50 MHz core clock and synchronous active-low reset
package quad_phase_pin_mux_pkg;

    // function that a pin carries once the select and the alternate bit are merged
    // four-state base so the code can travel on a wire port
    typedef enum logic [2:0] {
        FN_QUAD,
        FN_TIMER,
        FN_SPI,
        FN_GPIO,
        FN_NONE
    } pin_func_t;

    // software select codes on the per-pin select ports
    localparam logic [1:0] SEL_QUAD = 2'h0;
    localparam logic [1:0] SEL_TIMER = 2'h1;
    localparam logic [1:0] SEL_GPIO = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;

    // port c pull-up bit positions and reset value (pull-ups on out of reset)
    localparam int PUR_BIT_A = 0;
    localparam int PUR_BIT_B = 1;
    localparam logic [1:0] PUR_RESET = 2'h3;

    // port c direction and data reset values: inputs, low
    localparam logic [1:0] DIR_RESET = 2'h0;
    localparam logic [1:0] DATA_RESET = 2'h0;

    // level fed to a peripheral whose function is not on the pin (pulled-up idle)
    localparam logic IDLE_IN = 1'h1;

    // the alternate bit overrides the select and hands the pin to spi port 1
    function automatic pin_func_t decode_sel(input logic alt, input logic [1:0] sel);
        pin_func_t f;
        f = FN_NONE;
        if (alt) begin
            f = FN_SPI;
        end else begin
            case (sel)
                SEL_QUAD: f = FN_QUAD;
                SEL_TIMER: f = FN_TIMER;
                SEL_GPIO: f = FN_GPIO;
                default: f = FN_NONE;
            endcase
        end
        return f;
    endfunction : decode_sel

endpackage : quad_phase_pin_mux_pkg

// ### logic/pin_sync2.sv
// two-flop synchroniser for the pin inputs
// assumes the pin level is asynchronous to the core clock
`timescale 1ns/1ns
module pin_sync2 (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_async,
    output logic [1:0] o_sync
);
    logic [1:0] stage1_r;
    logic [1:0] stage1_nxt;
    logic [1:0] stage2_r;
    logic [1:0] stage2_nxt;

    // first stage is read only by the second stage
    always_comb begin
        stage1_nxt = i_async;
        stage2_nxt = stage1_r;
        if (!i_nrst) begin
            stage1_nxt = {2{quad_phase_pin_mux_pkg::IDLE_IN}};
            stage2_nxt = {2{quad_phase_pin_mux_pkg::IDLE_IN}};
        end
    end

    always_ff @(posedge i_clk) begin
        stage1_r <= stage1_nxt;
        stage2_r <= stage2_nxt;
    end

    assign o_sync = stage2_r;
endmodule : pin_sync2

// ### logic/pin_drive_cell.sv
// registered output stage of one multiplexed pin: level, enable and pull-up
// assumes the function code is already registered by the caller
`timescale 1ns/1ns
module pin_drive_cell (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire quad_phase_pin_mux_pkg::pin_func_t i_func,
    input wire logic i_timer_out,
    input wire logic i_timer_oe,
    input wire logic i_spi_out,
    input wire logic i_spi_oe,
    input wire logic i_gpio_out,
    input wire logic i_gpio_oe,
    input wire logic i_pullup,
    output logic o_out,
    output logic o_oe,
    output logic o_pullup
);
    logic out_r;
    logic out_nxt;
    logic oe_r;
    logic oe_nxt;
    logic pu_r;
    logic pu_nxt;

    // quad input and no function never drive; the pin stays an input
    always_comb begin
        out_nxt = 1'h0;
        oe_nxt = 1'h0;
        pu_nxt = i_pullup;
        case (i_func)
            quad_phase_pin_mux_pkg::FN_TIMER: begin
                out_nxt = i_timer_out;
                oe_nxt = i_timer_oe;
            end
            quad_phase_pin_mux_pkg::FN_SPI: begin
                out_nxt = i_spi_out;
                oe_nxt = i_spi_oe;
            end
            quad_phase_pin_mux_pkg::FN_GPIO: begin
                out_nxt = i_gpio_out;
                oe_nxt = i_gpio_oe;
            end
            default: begin
                out_nxt = 1'h0;
                oe_nxt = 1'h0;
            end
        endcase
        if (!i_nrst) begin
            out_nxt = 1'h0;
            oe_nxt = 1'h0;
            pu_nxt = 1'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        out_r <= out_nxt;
        oe_r <= oe_nxt;
        pu_r <= pu_nxt;
    end

    assign o_out = out_r;
    assign o_oe = oe_r;
    assign o_pullup = pu_r;
endmodule : pin_drive_cell

// ### verification/pin_pad_model.sv
// pad model: resolves one two-way pin from the mux drive, its pull-up and an outside driver
// assumes one core clock; the outside driver yields whenever the mux drives the pin
`timescale 1ns/1ns
module pin_pad_model (
    input wire logic i_clk,
    input wire logic i_oe,
    input wire logic i_out,
    input wire logic i_pullup,
    input wire logic i_ext_en,
    input wire logic i_ext_val,
    output logic o_level
);
    logic last_r = 1'b0;
    always_comb begin
        if (i_oe) begin
            o_level = i_out;
        end else if (i_ext_en) begin
            o_level = i_ext_val;
        end else if (i_pullup) begin
            o_level = 1'b1;
        end else begin
            o_level = ~last_r; // floating pin toggles so no stale level passes for a match
        end
    end
    always_ff @(posedge i_clk) begin
        last_r <= o_level;
    end
endmodule : pin_pad_model

// ### verification/testbench.sv
// self-checking bench for the two-pin phase mux with pad models on both pins
// assumes both variants share every control; only the full one drives the pads
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [1:0] sel_a;
        logic [1:0] sel_b;
        logic [1:0] alt;
        logic [1:0] dir;
        logic [1:0] data;
        logic [1:0] exp_oe;
        logic [1:0] exp_out;
    } row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sel_wr = 1'b0;
    logic [1:0] sel_a = 2'h0;
    logic [1:0] sel_b = 2'h0;
    logic [1:0] alt = 2'h0;
    logic [1:0] pur = 2'h3;
    logic [1:0] dir = 2'h0;
    logic [1:0] data = 2'h0;
    logic master = 1'b1;
    logic sclk_out = 1'b1;
    logic mosi_out = 1'b0;
    logic [1:0] ext_en = 2'h0;
    logic [1:0] ext_val = 2'h0;
    logic [1:0] tmr_oe = 2'h3;
    logic pin_a, pin_b, a_out, a_oe, a_pu, b_out, b_oe, b_pu;
    logic q_a, q_b, t_a, t_b, s_clk, s_mosi;
    logic [1:0] port_in, r_oe, r_quad;
    int error_cnt = 0;
    int n_compared = 0;
    // timer drives pin a high and pin b low whenever selected with tmr_oe set
    row_t rows [8] = '{
        '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0},
        '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h3, 2'h1},
        '{2'h2, 2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h1},
        '{2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2},
        '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h1},
        '{2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0},
        '{2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h3, 2'h1},
        '{2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2, 2'h0}
    };

    initial begin
        forever #10 clk = ~clk;
    end

    quad_phase_pin_mux u_dut (
        .I_CORE_CLK(clk), .I_NRST(nrst), .I_PIN_A_IN(pin_a), .I_PIN_B_IN(pin_b),
        .O_PIN_A_OUT(a_out), .O_PIN_A_OE(a_oe), .O_PIN_A_PULLUP(a_pu),
        .O_PIN_B_OUT(b_out), .O_PIN_B_OE(b_oe), .O_PIN_B_PULLUP(b_pu),
        .I_SEL_WR(sel_wr), .I_SEL_A(sel_a), .I_SEL_B(sel_b),
        .I_PHASE_A_ALT_SELECT(alt[0]), .I_PHASE_B_ALT_SELECT(alt[1]),
        .I_PORT_C_PULLUP(pur), .I_PORT_C_DIR(dir), .I_PORT_C_DATA(data),
        .I_TIMER_B_CH0_OUT(1'b1), .I_TIMER_B_CH0_OE(tmr_oe[0]),
        .I_TIMER_B_CH1_OUT(1'b0), .I_TIMER_B_CH1_OE(tmr_oe[1]),
        .I_SPI1_MASTER(master), .I_SPI1_CLOCK_OUT(sclk_out), .I_SPI1_MOSI_OUT(mosi_out),
        .O_QUAD1_PHASE_A_IN(q_a), .O_QUAD1_PHASE_B_IN(q_b),
        .O_TIMER_B_CH0_IN(t_a), .O_TIMER_B_CH1_IN(t_b),
        .O_SPI1_CLOCK_IN(s_clk), .O_SPI1_MOSI_IN(s_mosi), .O_PORT_C_IN(port_in)
    );
    pin_pad_model u_pad_a (.i_clk(clk), .i_oe(a_oe), .i_out(a_out), .i_pullup(a_pu),
        .i_ext_en(ext_en[0]), .i_ext_val(ext_val[0]), .o_level(pin_a));
    pin_pad_model u_pad_b (.i_clk(clk), .i_oe(b_oe), .i_out(b_out), .i_pullup(b_pu),
        .i_ext_en(ext_en[1]), .i_ext_val(ext_val[1]), .o_level(pin_b));
    // reduced variant on the same controls; only its drive enables and decoder inputs are watched
    quad_phase_pin_mux #(.FULL_VARIANT(1'b0)) u_dut_reduced (
        .I_CORE_CLK(clk), .I_NRST(nrst), .I_PIN_A_IN(pin_a), .I_PIN_B_IN(pin_b),
        .O_PIN_A_OUT(), .O_PIN_A_OE(r_oe[0]), .O_PIN_A_PULLUP(),
        .O_PIN_B_OUT(), .O_PIN_B_OE(r_oe[1]), .O_PIN_B_PULLUP(),
        .I_SEL_WR(sel_wr), .I_SEL_A(sel_a), .I_SEL_B(sel_b),
        .I_PHASE_A_ALT_SELECT(alt[0]), .I_PHASE_B_ALT_SELECT(alt[1]),
        .I_PORT_C_PULLUP(pur), .I_PORT_C_DIR(dir), .I_PORT_C_DATA(data),
        .I_TIMER_B_CH0_OUT(1'b1), .I_TIMER_B_CH0_OE(tmr_oe[0]),
        .I_TIMER_B_CH1_OUT(1'b0), .I_TIMER_B_CH1_OE(tmr_oe[1]),
        .I_SPI1_MASTER(master), .I_SPI1_CLOCK_OUT(sclk_out), .I_SPI1_MOSI_OUT(mosi_out),
        .O_QUAD1_PHASE_A_IN(r_quad[0]), .O_QUAD1_PHASE_B_IN(r_quad[1]),
        .O_TIMER_B_CH0_IN(), .O_TIMER_B_CH1_IN(),
        .O_SPI1_CLOCK_IN(), .O_SPI1_MOSI_IN(), .O_PORT_C_IN()
    );

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_pair(input string name, input logic [1:0] exp, input logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_pair

    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end

    initial begin
        // two edges in reset; the synchroniser loads a constant, so one edge already flushes it
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ext_en <= 2'h3;
        #1;
        cmp_pair("oe_in_reset", 2'h0, {b_oe, a_oe});
        cmp_pair("pullup_in_reset", 2'h3, {b_pu, a_pu});
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ext_val <= {2{k[0]}};
            repeat (4) @(posedge clk);
            #1;
            cmp_bit("quad_a_in", k[0], q_a);
            cmp_bit("quad_b_in", k[0], q_b);
            cmp_bit("timer_a_idle", 1'b1, t_a);
            cmp_pair("reduced_oe", 2'h0, r_oe);
            cmp_pair("reduced_quad_in", 2'h3, r_quad);
        end
        foreach (rows[i]) begin
            @(posedge clk);
            sel_a <= rows[i].sel_a;
            sel_b <= rows[i].sel_b;
            alt <= rows[i].alt;
            dir <= rows[i].dir;
            data <= rows[i].data;
            sel_wr <= 1'b1;
            @(posedge clk);
            sel_wr <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            cmp_pair("pin_oe", rows[i].exp_oe, {b_oe, a_oe});
            cmp_pair("pin_out", rows[i].exp_out, {b_out, a_out} & rows[i].exp_oe);
        end
        // timer and gpio take the undriven pins as inputs; the unselected user reads idle
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            alt <= 2'h0;
            tmr_oe <= 2'h0;
            sel_a <= k[1] ? 2'h2 : 2'h1;
            sel_b <= k[1] ? 2'h2 : 2'h1;
            ext_val <= {~k[0], k[0]};
            sel_wr <= 1'b1;
            @(posedge clk);
            sel_wr <= 1'b0;
            repeat (5) @(posedge clk);
            #1;
            cmp_pair("timer_in", k[1] ? 2'h3 : {~k[0], k[0]}, {t_b, t_a});
            cmp_pair("gpio_in", k[1] ? {~k[0], k[0]} : 2'h3, port_in);
        end
        // select takes effect one edge after the take edge, not at it
        @(posedge clk);
        alt <= 2'h0;
        dir <= 2'h0;
        tmr_oe <= 2'h3;
        sel_wr <= 1'b1;
        @(posedge clk);
        sel_wr <= 1'b0;
        repeat (3) @(posedge clk);
        sel_a <= 2'h1;
        sel_wr <= 1'b1;
        @(posedge clk);
        sel_wr <= 1'b0;
        #1;
        cmp_bit("oe_at_take", 1'b0, a_oe);
        @(posedge clk);
        #1;
        cmp_bit("oe_after_take", 1'b1, a_oe);
        for (int k = 1; k < 3; k++) begin
            @(posedge clk);
            pur <= 2'(k);
            repeat (2) @(posedge clk);
            #1;
            cmp_pair("pullup", 2'(k), {b_pu, a_pu});
        end
        // spi slave: clock pin is an input
        @(posedge clk);
        pur <= 2'h3;
        alt <= 2'h3;
        master <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ext_val <= {2{k[0]}};
            repeat (4) @(posedge clk);
            #1;
            cmp_bit("slave_clk_oe", 1'b0, a_oe);
            cmp_bit("slave_clk_in", k[0], s_clk);
            cmp_bit("slave_mosi_oe", 1'b0, b_oe);
            cmp_bit("slave_mosi_in", k[0], s_mosi);
        end
        // spi master: clock and data keep their relative timing on the pins
        @(posedge clk);
        master <= 1'b1;
        alt <= 2'h3;
        repeat (3) @(posedge clk);
        sclk_out <= 1'b0;
        mosi_out <= 1'b1;
        @(posedge clk);
        #1;
        cmp_pair("master_oe", 2'h3, {b_oe, a_oe});
        cmp_pair("master_out", 2'h2, {b_out, a_out});
        finish_test();
    end
endmodule : testbench
